// [ispc_ctrl.sv]
// In-system flash programming controller with APB register access
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Modify of application area while running from it sets fault.
// R2: Loader modify from application code with update enable 0 sets fault.
// R3: Any config byte access from application code sets fault.
// R4: Loader code modifying loader area itself sets fault.
// R5: Oversize address or run into external memory sets fault.
// R6: Fault flag ignores writes of one, clears only by software.
// R7: Update enable 0 keeps loader read-only to app; 1 gives full access.
// R8: Written boot select picks boot area after later resets. Here arst_n reloads it with BOOT_RESET.
// R9: Boot select reads the area actually booted from.
// R10: Programming enable starts the RC oscillator; disable stops it.
// R11: Software clears programming enable last to stop the oscillator.
// R12: Command holds area bits, output and chip enables, operation code.
// R13: Address bits 15:8 from high register, 7:0 from low register.
// R14: Software writes data byte before triggering a program.
// R15: Read result lands in flash data register by completion.
// R16: Writing one to trigger starts the selected operation.
// R17: CPU is stalled while the sequencer runs the operation.
// R18: Stall is released when the operation completes.
// R19: Trigger clears itself on completion and always reads zero.
// R20: Chip control and trigger writes need the timed-access unlock.
// R21: Programming enable one enables programming, zero disables it.
// R22: Software writes 0xAA then 0x55 to timed access before protected write.
// R23: Page erase clears a 128-byte page at an aligned address.
// R24: Operation codes and area encodings as in the command table.
// R25: On a violation no flash change; stall and trigger still end.
// R26: Trigger while programming is disabled starts nothing, no stall.
module ispc_ctrl
    import ispc_pkg::*;
#(
    parameter int          APP_SIZE    = 16384,
    parameter int          LOADER_SIZE = 2048,
    parameter int          CONFIG_SIZE = 4,
    parameter logic [7:0]  MAKER_CODE  = 8'h3C,  // Arbitrary value
    parameter logic        BOOT_RESET  = 1'b0
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  codeInLoader,
    input  wire logic                  runsExternal,
    input  wire logic                  bootedFromLoader,
    input  wire logic                  flashDone,
    input  wire logic [7:0]            flashRdData,
    output logic                       flashReq,
    output logic      [3:0]            flashOp,
    output logic      [1:0]            targetAreaSelect,
    output logic      [15:0]           flashAddr,
    output logic      [7:0]            flashWrData,
    output logic                       cpuStall,
    output logic                       rcOscEnable,
    output logic                       nextBootSelect
);
    //////////////////////////////////////////////////////////////////////////
    // Registers
    ispc_state_t state_r;
    ispc_state_t state_nxt;
    logic [7:0]  command_r;
    logic [7:0]  addrLow_r;
    logic [7:0]  addrHigh_r;
    logic [7:0]  flashData_r;
    logic        fault_r;
    logic        loaderUpdateEnable_r;
    logic        programEnable_r;
    logic        bootNext_r;
    logic        bootedFrom_r;
    logic        bootCaught_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        flashReq_r;
    logic        cpuStall_r;
    logic        unlocked;

    //////////////////////////////////////////////////////////////////////////
    // APB decode
    wire [APB_ADDR_W-3:0] regIdx = paddr[APB_ADDR_W-1:2];
    wire       setup    = psel && !penable;
    wire       wrStrobe = psel && penable && pwrite && pready_r && (paddr[1:0] == 2'b00);
    wire [7:0] wrByte   = pwdata[7:0];

    wire hitChip    = (regIdx == {2'b00, IDX_CHIP_CONTROL});
    wire hitTrigger = (regIdx == {2'b00, IDX_TRIGGER});
    wire hitLow     = (regIdx == {2'b00, IDX_ADDR_LOW});
    wire hitHigh    = (regIdx == {2'b00, IDX_ADDR_HIGH});
    wire hitData    = (regIdx == {2'b00, IDX_FLASH_DATA});
    wire hitCommand = (regIdx == {2'b00, IDX_COMMAND});
    wire hitUnlock  = (regIdx == {2'b00, IDX_TIMED_ACCESS});
    wire hitAny     = hitChip || hitTrigger || hitLow || hitHigh || hitData
                    || hitCommand || hitUnlock;
    wire aligned    = (paddr[1:0] == 2'b00);

    wire wrChip    = wrStrobe && hitChip && unlocked;      // see R20
    wire wrTrigger = wrStrobe && hitTrigger && unlocked;   // see R20

    ispc_unlock u_unlock (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .wrStrobe   (wrStrobe),
        .wrToUnlock (hitUnlock),
        .wrData     (wrByte),
        .unlocked   (unlocked)
    );

    // Chip control read: reserved bits and reset request read zero
    wire [7:0] chipRead = {1'b0, fault_r, loaderUpdateEnable_r, 3'b000,
                           bootedFrom_r, programEnable_r};              // see R9

    wire [7:0] readByte = hitChip    ? chipRead    :
                          hitLow     ? addrLow_r   :
                          hitHigh    ? addrHigh_r  :
                          hitData    ? flashData_r :
                          hitCommand ? command_r   : 8'h00;             // see R19

    //////////////////////////////////////////////////////////////////////////
    // Command decode
    wire [1:0]  area      = command_r[CMD_AREA_HI:CMD_AREA_LO];          // see R12
    wire [3:0]  opCode    = command_r[3:0];                             // see R12
    wire        chipOff   = command_r[CMD_CHIP_EN];
    wire [17:0] target    = {area, addrHigh_r, addrLow_r};              // see R13
    wire        isModify  = (opCode == OP_PROGRAM) || (opCode == OP_PAGE_ERASE);
    wire        isRead    = (opCode == OP_READ);
    wire        isMaker   = (opCode == OP_MAKER_CODE);                  // see R24
    wire        isFlashOp = (isModify || isRead) && !chipOff;
    wire        inApp     = !codeInLoader;

    wire [16:0] offset17  = {1'b0, target[15:0]};
    wire        tooBig    = (area == AREA_APP)    ? (offset17 >= 17'(APP_SIZE))    :
                            (area == AREA_LOADER) ? (offset17 >= 17'(LOADER_SIZE)) :
                            (area == AREA_CONFIG) ? (offset17 >= 17'(CONFIG_SIZE)) :
                            1'b1;                                       // see R24

    wire faultAppSelf  = (area == AREA_APP) && isModify && inApp;       // see R1
    wire faultLoadLock = (area == AREA_LOADER) && isModify && inApp
                       && !loaderUpdateEnable_r;                        // see R2, R7
    wire faultConfig   = (area == AREA_CONFIG) && (isModify || isRead) && inApp; // see R3
    wire faultLoadSelf = (area == AREA_LOADER) && isModify && codeInLoader;      // see R4
    wire faultSize     = tooBig || runsExternal;                       // see R5
    wire violation     = isFlashOp && (faultAppSelf || faultLoadLock || faultConfig
                       || faultLoadSelf || faultSize);

    // Erase targets the page base
    wire [15:0] pageMask  = 16'hFFFF << PAGE_BITS;
    wire [15:0] opAddr    = (opCode == OP_PAGE_ERASE) ? (target[15:0] & pageMask)
                                                      : target[15:0];   // see R23

    wire startOp   = wrTrigger && wrByte[TRG_GO] && programEnable_r
                   && (state_r == ST_IDLE);                             // see R16, R26
    wire issueOp   = (state_r == ST_CHECK) && isFlashOp && !violation;
    wire setFault  = (state_r == ST_CHECK) && violation;
    wire readBack  = (state_r == ST_WAIT) && flashDone && isRead;
    wire makerBack = (state_r == ST_CHECK) && isMaker;

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
                if (startOp)
                    state_nxt = ST_CHECK;                               // see R17
            ST_CHECK:
                if (issueOp)
                    state_nxt = ST_WAIT;
                else
                    state_nxt = ST_END;                                 // see R25
            ST_WAIT:
                if (flashDone)
                    state_nxt = ST_END;
            ST_END:
                state_nxt = ST_IDLE;                                    // see R18, R19
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Stall from the trigger until the end state
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cpuStall_r <= 1'b0;
        else if (startOp)
            cpuStall_r <= 1'b1;                                         // see R17
        else if (state_r == ST_END)
            cpuStall_r <= 1'b0;                                         // see R18, R25
    end

    // Flash request pulse; no request on a violation
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            flashReq_r <= 1'b0;
        else
            flashReq_r <= issueOp;                                      // see R25
    end

    //////////////////////////////////////////////////////////////////////////
    // Software-visible registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            command_r  <= RST_COMMAND;
            addrLow_r  <= RST_BYTE;
            addrHigh_r <= RST_BYTE;
        end
        else if (wrStrobe)
        begin
            if (hitCommand)
                command_r <= wrByte;
            if (hitLow)
                addrLow_r <= wrByte;
            if (hitHigh)
                addrHigh_r <= wrByte;
        end
    end

    // Hardware result wins over a software write in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            flashData_r <= RST_BYTE;
        else if (readBack)
            flashData_r <= flashRdData;                                 // see R15
        else if (makerBack)
            flashData_r <= MAKER_CODE;                                  // see R15
        else if (wrStrobe && hitData)
            flashData_r <= wrByte;
    end

    // Fault: set wins over clear; a write of one does nothing
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            fault_r <= 1'b0;
        else if (setFault)
            fault_r <= 1'b1;
        else if (wrChip && !wrByte[CC_FAULT])
            fault_r <= 1'b0;                                            // see R6
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            loaderUpdateEnable_r <= 1'b0;
            programEnable_r      <= 1'b0;
            bootNext_r           <= BOOT_RESET;
        end
        else if (wrChip)
        begin
            loaderUpdateEnable_r <= wrByte[CC_LDR_UPD];                 // see R7
            programEnable_r      <= wrByte[CC_PROG_EN];                 // see R21
            bootNext_r           <= wrByte[CC_BOOT_SEL];                // see R8
        end
    end

    // Boot area caught once, on the first edge after reset release
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bootedFrom_r <= 1'b0;
            bootCaught_r <= 1'b0;
        end
        else if (!bootCaught_r)
        begin
            bootedFrom_r <= bootedFromLoader;                           // see R9
            bootCaught_r <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // APB answer: ready in the first access cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else if (setup)
        begin
            pready_r  <= 1'b1;
            pslverr_r <= !(hitAny && aligned);
            prdata_r  <= {24'h00_0000, (hitAny && aligned) ? readByte : 8'h00};
        end
        else
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign flashReq         = flashReq_r;
    assign flashOp          = command_r[3:0];
    assign targetAreaSelect = command_r[CMD_AREA_HI:CMD_AREA_LO];
    assign flashAddr        = opAddr;
    assign flashWrData      = flashData_r;
    assign cpuStall         = cpuStall_r;
    assign rcOscEnable      = programEnable_r;                          // see R10, R11
    assign nextBootSelect   = bootNext_r;                               // see R8
endmodule
`default_nettype wire

// [ispc_pkg.sv]
// Constants for the in-system flash programming controller
package ispc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CHIP_CONTROL  = 8'h9F;
    localparam logic [7:0]  IDX_TRIGGER       = 8'hA4;
    localparam logic [7:0]  IDX_ADDR_LOW      = 8'hA6;
    localparam logic [7:0]  IDX_ADDR_HIGH     = 8'hA7;
    localparam logic [7:0]  IDX_FLASH_DATA    = 8'hAE;
    localparam logic [7:0]  IDX_COMMAND       = 8'hAF;
    localparam logic [7:0]  IDX_TIMED_ACCESS  = 8'hC7;
    localparam int          APB_ADDR_W        = 12;
    // Reset values
    localparam logic [7:0]  RST_COMMAND       = 8'h30;
    localparam logic [7:0]  RST_BYTE          = 8'h00;
    // Chip control field positions
    localparam int          CC_FAULT          = 6;
    localparam int          CC_LDR_UPD        = 5;
    localparam int          CC_BOOT_SEL       = 1;
    localparam int          CC_PROG_EN        = 0;
    localparam int          TRG_GO            = 0;
    // Command fields
    localparam int          CMD_AREA_HI       = 7;
    localparam int          CMD_AREA_LO       = 6;
    localparam int          CMD_OUT_EN        = 5;
    localparam int          CMD_CHIP_EN       = 4;
    // Operation codes
    localparam logic [3:0]  OP_READ           = 4'h0;
    localparam logic [3:0]  OP_PROGRAM        = 4'h1;
    localparam logic [3:0]  OP_PAGE_ERASE     = 4'h2;
    localparam logic [3:0]  OP_MAKER_CODE     = 4'hB;
    // Target areas
    localparam logic [1:0]  AREA_APP          = 2'b00;
    localparam logic [1:0]  AREA_LOADER       = 2'b01;
    localparam logic [1:0]  AREA_CONFIG       = 2'b11;
    // Page erase alignment: 128-byte pages
    localparam int          PAGE_BITS         = 7;
    // Timed-access unlock sequence
    localparam logic [7:0]  UNLOCK_FIRST      = 8'hAA;
    localparam logic [7:0]  UNLOCK_SECOND     = 8'h55;
    // Controller states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_WAIT  = 2'b10,
        ST_END   = 2'b11
    } ispc_state_t;
    typedef enum logic [1:0] {
        UL_IDLE  = 2'b00,
        UL_FIRST = 2'b01,
        UL_OPEN  = 2'b10
    } ispc_unlock_t;
endpackage

// [ispc_unlock.sv]
// Timed-access unlock tracker for protected registers
`timescale 1ns/1ps
`default_nettype none
module ispc_unlock
    import ispc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       wrStrobe,
    input  wire logic       wrToUnlock,
    input  wire logic [7:0] wrData,
    output logic            unlocked
);
    ispc_unlock_t state_r;
    ispc_unlock_t state_nxt;

    wire gotFirst  = wrToUnlock && (wrData == UNLOCK_FIRST);
    wire gotSecond = wrToUnlock && (wrData == UNLOCK_SECOND) && (state_r == UL_FIRST);

    // Any other write closes the window, so one unlock covers one write
    always_comb
    begin
        state_nxt = state_r;
        if (wrStrobe)
        begin
            if (gotSecond)
                state_nxt = UL_OPEN;
            else if (gotFirst)
                state_nxt = UL_FIRST;
            else
                state_nxt = UL_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= UL_IDLE;
        else
            state_r <= state_nxt;
    end

    assign unlocked = (state_r == UL_OPEN);
endmodule
`default_nettype wire

// [ispc_ctrl_props.sv]
// Port assertions for the flash programming controller
`timescale 1ns/1ps
`default_nettype none
module ispc_ctrl_props
    import ispc_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  flashDone,
    input wire logic                  flashReq,
    input wire logic [3:0]            flashOp,
    input wire logic [15:0]           flashAddr,
    input wire logic                  cpuStall,
    input wire logic                  rcOscEnable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire logic accDone = psel && penable && pready;
    wire logic rdAt    = accDone && !pwrite;
    wire logic trgGo   = accDone && pwrite && paddr == 12'h290 && pwdata[0];
    //////////////////////////////////////////////////////////////////////////
    sequence s_setup; psel && !penable; endsequence
    sequence s_finish; cpuStall ##[1:3] !cpuStall; endsequence
    property p_ready; s_setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("pready held too long");
    property p_err; accDone && paddr[1:0] != 2'b00 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unaligned access accepted");
    property p_osc; rdAt && paddr == 12'h27C |-> prdata[0] == rcOscEnable; endproperty
    a_osc: assert property (p_osc) else $error("oscillator differs from enable");
    property p_trg0; rdAt && paddr == 12'h290 |-> prdata == 32'h00000000; endproperty
    a_trg0: assert property (p_trg0) else $error("trigger reads nonzero");
    property p_off; trgGo && !rcOscEnable |=> !cpuStall [*2]; endproperty
    a_off: assert property (p_off) else $error("stall while disabled");
    property p_req; flashReq |-> cpuStall && $past(cpuStall); endproperty
    a_req: assert property (p_req) else $error("flash request without stall");
    property p_rpulse; flashReq |=> !flashReq; endproperty
    a_rpulse: assert property (p_rpulse) else $error("request longer than a cycle");
    property p_done; flashDone && cpuStall |=> s_finish; endproperty
    a_done: assert property (p_done) else $error("stall not released");
    property p_page; flashReq && flashOp == OP_PAGE_ERASE |-> flashAddr[6:0] == 7'h00; endproperty
    a_page: assert property (p_page) else $error("erase address not page aligned");
endmodule
bind ispc_ctrl ispc_ctrl_props u_ispc_ctrl_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashDone(flashDone), .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr),
    .cpuStall(cpuStall), .rcOscEnable(rcOscEnable));
`default_nettype wire

// [ispc_flash_model.sv]
// Behavioural flash array answering the controller's requests
`timescale 1ns/1ps
`default_nettype none
module ispc_flash_model
    import ispc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        flashReq,
    input wire logic [3:0]  flashOp,
    input wire logic [1:0]  targetAreaSelect,
    input wire logic [15:0] flashAddr,
    input wire logic [7:0]  flashWrData,
    input wire logic [7:0]  respDelay,
    output logic            flashDone,
    output logic [7:0]      flashRdData
);
    logic [7:0]  mem [logic [17:0]];
    logic [17:0] addr;
    int          waitCnt = -1;
    int          opCount = 0;
    initial flashDone = 1'b0;
    initial flashRdData = 8'h00;
    //////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk)
    begin
        flashDone <= 1'b0;
        // Data bus is driven with toggling junk outside the answer cycle
        flashRdData <= ~flashRdData;
        if (flashReq)
        begin
            addr = {targetAreaSelect, flashAddr};
            opCount++;
            waitCnt = respDelay;
            case (flashOp)
                OP_PROGRAM: mem[addr] = flashWrData;
                OP_PAGE_ERASE: for (int i = 0; i < 128; i++) mem.delete({addr[17:7], 7'(i)});
                default: ;
            endcase
        end
        else if (waitCnt == 0)
        begin
            flashDone <= 1'b1;
            flashRdData <= mem.exists(addr) ? mem[addr] : 8'hFF;
        end
        if (waitCnt >= 0)
            waitCnt--;
    end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the flash programming controller
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ispc_pkg::*;
;
    localparam logic [7:0] MAKER_V = 8'h5A; // Arbitrary value
    logic        sys_clk, arst_n, psel, penable, pwrite, codeInLoader, runsExternal;
    logic        bootedFromLoader, pready, pslverr, flashDone, flashReq, cpuStall, e;
    logic        rcOscEnable, nextBootSelect;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  flashRdData, flashWrData, respDelay;
    logic [3:0]  flashOp;
    logic [1:0]  targetAreaSelect;
    logic [15:0] flashAddr;
    int          failures, checks_done, cycles;
    ispc_ctrl #(.MAKER_CODE(MAKER_V)) u_ispc_ctrl (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .codeInLoader(codeInLoader), .runsExternal(runsExternal),
        .bootedFromLoader(bootedFromLoader), .flashDone(flashDone),
        .flashRdData(flashRdData), .flashReq(flashReq), .flashOp(flashOp),
        .targetAreaSelect(targetAreaSelect), .flashAddr(flashAddr),
        .flashWrData(flashWrData), .cpuStall(cpuStall), .rcOscEnable(rcOscEnable),
        .nextBootSelect(nextBootSelect));
    ispc_flash_model u_ispc_flash_model (
        .sys_clk(sys_clk), .flashReq(flashReq), .flashOp(flashOp),
        .targetAreaSelect(targetAreaSelect), .flashAddr(flashAddr),
        .flashWrData(flashWrData), .respDelay(respDelay), .flashDone(flashDone),
        .flashRdData(flashRdData));
    //////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            failures++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] x);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        chk(r, {24'h000000, x});
    endtask
    task automatic pwr(input logic [7:0] idx, input logic [7:0] d);
        wr(IDX_TIMED_ACCESS, UNLOCK_FIRST);
        wr(IDX_TIMED_ACCESS, UNLOCK_SECOND);
        wr(idx, d);
    endtask
    task automatic op(input logic [7:0] cmd);
        int n;
        n = 0;
        wr(IDX_COMMAND, cmd);
        pwr(IDX_TRIGGER, 8'h01);
        repeat (2) @(posedge sys_clk);
        while (cpuStall !== 1'b0 && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 300)
            failures++;
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(IDX_COMMAND, RST_COMMAND);
        rdc(IDX_ADDR_LOW, RST_BYTE);
        rdc(IDX_ADDR_HIGH, RST_BYTE);
        rdc(IDX_FLASH_DATA, RST_BYTE);
        rdc(IDX_TRIGGER, RST_BYTE);
        rdc(IDX_CHIP_CONTROL, 8'h00);
        apb(1'b0, 12'h010, 8'h00);
        chk(e, 1'b1);
        chk(r, 32'h00000000);
        apb(1'b1, 12'h299, 8'h77);
        chk(e, 1'b1);
        rdc(IDX_ADDR_LOW, RST_BYTE);
    endtask
    task automatic t_protect();
        wr(IDX_CHIP_CONTROL, 8'h01);
        rdc(IDX_CHIP_CONTROL, 8'h00);
        pwr(IDX_TRIGGER, 8'h01);
        repeat (3) @(posedge sys_clk);
        chk(cpuStall, 1'b0);
        pwr(IDX_CHIP_CONTROL, 8'h03);
        rdc(IDX_CHIP_CONTROL, 8'h01);
        chk(nextBootSelect, 1'b1);
        chk(rcOscEnable, 1'b1);
        wr(IDX_TRIGGER, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk(cpuStall, 1'b0);
    endtask
    task automatic t_ops();
        codeInLoader <= 1'b1;
        wr(IDX_ADDR_HIGH, 8'h12);
        wr(IDX_ADDR_LOW, 8'h34);
        wr(IDX_FLASH_DATA, 8'hA5);
        op(8'h21);
        chk(u_ispc_flash_model.mem[18'h01234], 8'hA5);
        respDelay <= 8'h14;
        wr(IDX_FLASH_DATA, 8'h00);
        op(8'h00);
        rdc(IDX_FLASH_DATA, 8'hA5);
        respDelay <= 8'h01;
        op(8'h22);
        op(8'h00);
        rdc(IDX_FLASH_DATA, 8'hFF);
        op(8'h0B);
        rdc(IDX_FLASH_DATA, MAKER_V);
    endtask
    task automatic t_faults();
        logic [7:0] cmd [8] = '{8'h21, 8'h61, 8'h61, 8'h40, 8'hC0, 8'h61, 8'h21, 8'h21};
        logic [7:0] hi [8] = '{8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h12};
        // Per case: loader code, update enable, external run, fault expected
        logic [3:0] cfg [8] = '{4'h1, 4'h1, 4'h4, 4'h0, 4'h1, 4'h9, 4'h9, 4'hB};
        int n;
        for (int i = 0; i < 8; i++)
        begin
            codeInLoader <= cfg[i][3];
            runsExternal <= cfg[i][1];
            pwr(IDX_CHIP_CONTROL, {2'b00, cfg[i][2], 5'h03});
            wr(IDX_ADDR_HIGH, hi[i]);
            n = u_ispc_flash_model.opCount;
            op(cmd[i]);
            rdc(IDX_CHIP_CONTROL, {1'b0, cfg[i][0], cfg[i][2], 5'h01});
            chk(u_ispc_flash_model.opCount - n, {31'h0, !cfg[i][0]});
        end
        runsExternal <= 1'b0;
        pwr(IDX_CHIP_CONTROL, 8'h43);
        rdc(IDX_CHIP_CONTROL, 8'h41);
        pwr(IDX_CHIP_CONTROL, 8'h03);
        rdc(IDX_CHIP_CONTROL, 8'h01);
        pwr(IDX_CHIP_CONTROL, 8'h02);
        @(posedge sys_clk);
        chk(rcOscEnable, 1'b0);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end
    initial
    begin
        {arst_n, psel, penable, pwrite, codeInLoader, runsExternal, bootedFromLoader} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        respDelay = 8'h01;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_protect();
        t_ops();
        t_faults();
        give_verdict();
    end
endmodule
`default_nettype wire
